// >>> rtl/rif_defs.svh
// Offsets, codes and reset values of the receive-notification framer.
// Included by the framer, the only design file that needs a figure; the package does not include it.
`ifndef RIF_DEFS_SVH
`define RIF_DEFS_SVH
// Register offsets (byte addresses)
`define RIF_REG_CTRL 8'h00
`define RIF_REG_DEST_HIGH 8'h04
`define RIF_REG_DEST_LOW 8'h08
`define RIF_REG_STATUS 8'h0C
// Control fields
`define RIF_CTRL_API_EN_BIT 0
`define RIF_CTRL_FMT_LSB 1
`define RIF_CTRL_RST 32'h0000_0001
`define RIF_DEST_RST 32'h0000_0000
// Format select values
`define RIF_FMT_STD 2'h0
`define RIF_FMT_LEGACY 2'h2
// Frame bytes
`define RIF_START_DELIM 8'h7E
`define RIF_TYPE_ADDR_UPD 8'h8E
`define RIF_TYPE_LEGACY 8'h80
`define RIF_TYPE_STD 8'h90
`define RIF_FORMAT_ID 8'h00
`define RIF_RSVD_HI 8'hFF
`define RIF_RSVD_LO 8'hFE
`define RIF_CSUM_BASE 8'hFF
// Frame positions
`define RIF_IDX_LEN_MSB 5'h01
`define RIF_IDX_LEN_LSB 5'h02
`define RIF_IDX_TYPE 5'h03
`define RIF_IDX_FID 5'h04
`define RIF_IDX_NEW_LAST 5'h0C
`define RIF_IDX_OLD_LAST 5'h14
`define RIF_IDX_SRC_LAST 5'h0B
`define RIF_IDX_RSSI 5'h0C
`define RIF_IDX_LEG_OPT 5'h0D
`define RIF_IDX_RSV0 5'h0C
`define RIF_IDX_RSV1 5'h0D
`define RIF_IDX_STD_OPT 5'h0E
// Frame data lengths before payload (type through last header byte)
`define RIF_LEN_ADDR_UPD 16'h0012
`define RIF_LEN_LEGACY_HDR 16'h000B
`define RIF_LEN_STD_HDR 16'h000C
`endif

// >>> rtl/rif_pkg.sv
// Types of the receive-notification framer.
// Assumes rif_defs.svh holds the frame and register figures; the state and kind codes are set here.
package rif_pkg;
    typedef enum logic [3:0] {
        RIF_IDLE = 4'b0001,
        RIF_HDR = 4'b0010,
        RIF_PLD = 4'b0100,
        RIF_CSUM = 4'b1000
    } rif_state_t;
    typedef enum logic [1:0] {
        RIF_K_ADDR = 2'h0,
        RIF_K_LEGACY = 2'h1,
        RIF_K_STD = 2'h2
    } rif_kind_t;
endpackage : rif_pkg

// >>> rtl/rif_fifo.sv
// Payload FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module rif_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q, wr_d, rd_q, rd_d;
    logic push, pop;

    assign in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
    assign out_valid = wr_q != rd_q;
    assign out_data = mem_q[rd_q[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        wr_d = push ? wr_q + 1'b1 : wr_q;
        rd_d = pop ? rd_q + 1'b1 : rd_q;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
        end
    end

    // Storage needs no reset; only pointers define contents
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end
endmodule : rif_fifo

// >>> rtl/rif_framer.sv
// Receive-notification framer: address-update, legacy and standard rx frames.
// Assumes all inputs come from logic on CORE_CLK; serial line sits downstream.
`timescale 1ns/1ps
`include "rif_defs.svh"
// What this block does
// - Address update emits 0x8E frame when API enabled
// - Update frame byte 4 is zero
// - New then old address, MSB first
// - Format 2 sends type 0x80 frames
// - Source address bytes 4-11 MSB first
// - Legacy byte 12 holds RSSI magnitude
// - Legacy options: ack, broadcast, method bits
// - Format 0 sends 0x90, reserved 12-13
// - Standard options byte at offset 14
// - Standard payload starts at offset 15
module rif_framer import rif_pkg::*; #(
    parameter int LEN_W = 8,
    parameter int FIFO_DEPTH = 32
) (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    input wire logic UPD_VALID,
    output logic UPD_READY,
    input wire logic [63:0] UPD_ADDR,
    input wire logic RX_VALID,
    output logic RX_READY,
    input wire logic [63:0] RX_SRC_ADDR,
    input wire logic [7:0] RX_RSSI,
    input wire logic RX_ACKED,
    input wire logic RX_BCAST,
    input wire logic [1:0] RX_METHOD,
    input wire logic [LEN_W-1:0] RX_LEN,
    input wire logic PLD_VALID,
    output logic PLD_READY,
    input wire logic [7:0] PLD_DATA,
    output logic TX_VALID,
    input wire logic TX_READY,
    output logic [7:0] TX_DATA,
    output logic TX_LAST
);
    rif_state_t state_q, state_d;
    rif_kind_t kind_q, kind_d;
    logic [4:0] idx_q, idx_d;
    logic [LEN_W-1:0] rem_q, rem_d;
    logic [63:0] addr_a_q, addr_a_d, addr_b_q, addr_b_d;
    logic [7:0] rssi_q, rssi_d, opt_q, opt_d, sum_q, sum_d;
    logic emit_q, emit_d;
    logic [7:0] out_data_q, out_data_d;
    logic out_valid_q, out_valid_d, out_last_q, out_last_d;
    logic [15:0] frames_q, frames_d;
    logic [31:0] ctrl_q, ctrl_d, dh_q, dh_d, dl_q, dl_d, rdata_q, rdata_d;
    logic f_valid, f_ready;
    logic [7:0] f_data;
    logic api_en;
    logic [1:0] fmt_sel;
    logic load, upd_take, rx_take, fire;
    logic [4:0] hdr_last;
    logic [15:0] flen;
    logic [7:0] hdr_b, cur_b;
    logic [2:0] ka, kb;

    rif_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .in_valid(PLD_VALID),
        .in_ready(PLD_READY),
        .in_data(PLD_DATA),
        .out_valid(f_valid),
        .out_ready(f_ready),
        .out_data(f_data)
    );

    assign api_en = ctrl_q[`RIF_CTRL_API_EN_BIT];
    assign fmt_sel = ctrl_q[`RIF_CTRL_FMT_LSB +: 2];
    assign load = !out_valid_q || TX_READY;
    assign UPD_READY = state_q == RIF_IDLE;
    // Address update takes priority over a waiting packet
    assign RX_READY = (state_q == RIF_IDLE) && !UPD_VALID;
    assign upd_take = UPD_VALID && UPD_READY;
    assign rx_take = RX_VALID && RX_READY;
    assign TX_VALID = out_valid_q;
    assign TX_DATA = out_data_q;
    assign TX_LAST = out_last_q;
    assign REG_RDATA = rdata_q;

    always_comb begin
        case (kind_q)
            RIF_K_ADDR: hdr_last = `RIF_IDX_OLD_LAST;
            RIF_K_LEGACY: hdr_last = `RIF_IDX_LEG_OPT;
            default: hdr_last = `RIF_IDX_STD_OPT;
        endcase
        case (kind_q)
            RIF_K_ADDR: flen = `RIF_LEN_ADDR_UPD;
            RIF_K_LEGACY: flen = `RIF_LEN_LEGACY_HDR + 16'(rem_q);
            default: flen = `RIF_LEN_STD_HDR + 16'(rem_q);
        endcase
        ka = (kind_q == RIF_K_ADDR) ? 3'(`RIF_IDX_NEW_LAST - idx_q)
                                    : 3'(`RIF_IDX_SRC_LAST - idx_q);
        kb = 3'(`RIF_IDX_OLD_LAST - idx_q);
        hdr_b = 8'h00;
        if (idx_q == 5'h00) begin
            hdr_b = `RIF_START_DELIM;
        end else if (idx_q == `RIF_IDX_LEN_MSB) begin
            hdr_b = flen[15:8];
        end else if (idx_q == `RIF_IDX_LEN_LSB) begin
            hdr_b = flen[7:0];
        end else if (idx_q == `RIF_IDX_TYPE) begin
            case (kind_q)
                RIF_K_ADDR: hdr_b = `RIF_TYPE_ADDR_UPD;
                RIF_K_LEGACY: hdr_b = `RIF_TYPE_LEGACY;
                default: hdr_b = `RIF_TYPE_STD;
            endcase
        end else if (kind_q == RIF_K_ADDR) begin
            if (idx_q == `RIF_IDX_FID) begin
                hdr_b = `RIF_FORMAT_ID;
            end else if (idx_q <= `RIF_IDX_NEW_LAST) begin
                hdr_b = addr_a_q[{ka, 3'b000} +: 8];
            end else begin
                hdr_b = addr_b_q[{kb, 3'b000} +: 8];
            end
        end else if (idx_q <= `RIF_IDX_SRC_LAST) begin
            hdr_b = addr_a_q[{ka, 3'b000} +: 8];
        end else if (kind_q == RIF_K_LEGACY) begin
            hdr_b = (idx_q == `RIF_IDX_RSSI) ? rssi_q : opt_q;
        end else if (idx_q == `RIF_IDX_RSV0) begin
            hdr_b = `RIF_RSVD_HI;
        end else if (idx_q == `RIF_IDX_RSV1) begin
            hdr_b = `RIF_RSVD_LO;
        end else begin
            hdr_b = opt_q;
        end
    end

    always_comb begin
        state_d = state_q;
        kind_d = kind_q;
        idx_d = idx_q;
        rem_d = rem_q;
        addr_a_d = addr_a_q;
        addr_b_d = addr_b_q;
        rssi_d = rssi_q;
        opt_d = opt_q;
        sum_d = sum_q;
        emit_d = emit_q;
        frames_d = frames_q;
        out_valid_d = out_valid_q && !TX_READY;
        out_data_d = out_data_q;
        out_last_d = out_last_q;
        f_ready = 1'b0;
        fire = 1'b0;
        cur_b = hdr_b;
        case (state_q)
            RIF_IDLE: begin
                idx_d = 5'h00;
                sum_d = 8'h00;
                if (upd_take) begin
                    addr_a_d = UPD_ADDR;
                    addr_b_d = {dh_q, dl_q};
                    kind_d = RIF_K_ADDR;
                    rem_d = '0;
                    emit_d = 1'b1;
                    if (api_en) begin
                        state_d = RIF_HDR;
                    end
                end else if (rx_take) begin
                    addr_a_d = RX_SRC_ADDR;
                    rssi_d = RX_RSSI;
                    // Undefined option bits stay zero for the host to skip
                    opt_d = {RX_METHOD, 4'h0, RX_BCAST, RX_ACKED};
                    rem_d = RX_LEN;
                    kind_d = (fmt_sel == `RIF_FMT_LEGACY) ? RIF_K_LEGACY : RIF_K_STD;
                    // Other formats belong to another framer; payload is drained
                    emit_d = api_en && (fmt_sel == `RIF_FMT_LEGACY || fmt_sel == `RIF_FMT_STD);
                    if (RX_LEN != '0) begin
                        state_d = (emit_d) ? RIF_HDR : RIF_PLD;
                    end else begin
                        state_d = (emit_d) ? RIF_HDR : RIF_IDLE;
                    end
                end
            end
            RIF_HDR: begin
                if (load) begin
                    fire = 1'b1;
                    idx_d = idx_q + 5'h01;
                    if (idx_q == hdr_last) begin
                        state_d = (rem_q != '0) ? RIF_PLD : RIF_CSUM;
                    end
                end
            end
            RIF_PLD: begin
                cur_b = f_data;
                f_ready = emit_q ? load : 1'b1;
                if (f_valid && f_ready) begin
                    fire = emit_q;
                    rem_d = rem_q - 1'b1;
                    if (rem_q == LEN_W'(1)) begin
                        state_d = emit_q ? RIF_CSUM : RIF_IDLE;
                    end
                end
            end
            RIF_CSUM: begin
                cur_b = `RIF_CSUM_BASE - sum_q;
                if (load) begin
                    fire = 1'b1;
                    frames_d = frames_q + 16'h0001;
                    state_d = RIF_IDLE;
                end
            end
            default: state_d = RIF_IDLE;
        endcase
        if (fire) begin
            out_valid_d = 1'b1;
            out_data_d = cur_b;
            out_last_d = state_q == RIF_CSUM;
            if (state_q == RIF_PLD || idx_q >= `RIF_IDX_TYPE) begin
                sum_d = sum_q + cur_b;
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            state_q <= RIF_IDLE;
            kind_q <= RIF_K_ADDR;
            idx_q <= 5'h00;
            rem_q <= '0;
            addr_a_q <= '0;
            addr_b_q <= '0;
            rssi_q <= 8'h00;
            opt_q <= 8'h00;
            sum_q <= 8'h00;
            emit_q <= 1'b0;
            frames_q <= 16'h0000;
            out_valid_q <= 1'b0;
            out_data_q <= 8'h00;
            out_last_q <= 1'b0;
        end else begin
            state_q <= state_d;
            kind_q <= kind_d;
            idx_q <= idx_d;
            rem_q <= rem_d;
            addr_a_q <= addr_a_d;
            addr_b_q <= addr_b_d;
            rssi_q <= rssi_d;
            opt_q <= opt_d;
            sum_q <= sum_d;
            emit_q <= emit_d;
            frames_q <= frames_d;
            out_valid_q <= out_valid_d;
            out_data_q <= out_data_d;
            out_last_q <= out_last_d;
        end
    end

    // Register file; a network update wins over a software write
    always_comb begin
        ctrl_d = ctrl_q;
        dh_d = dh_q;
        dl_d = dl_q;
        rdata_d = 32'h0000_0000;
        if (REG_WR) begin
            case (REG_ADDR)
                `RIF_REG_CTRL: ctrl_d = {29'h0000_0000, REG_WDATA[2:0]};
                `RIF_REG_DEST_HIGH: dh_d = REG_WDATA;
                `RIF_REG_DEST_LOW: dl_d = REG_WDATA;
                default: ;
            endcase
        end
        if (upd_take) begin
            dh_d = UPD_ADDR[63:32];
            dl_d = UPD_ADDR[31:0];
        end
        if (REG_RD) begin
            case (REG_ADDR)
                `RIF_REG_CTRL: rdata_d = ctrl_q;
                `RIF_REG_DEST_HIGH: rdata_d = dh_q;
                `RIF_REG_DEST_LOW: rdata_d = dl_q;
                `RIF_REG_STATUS: rdata_d = {frames_q, 10'h000, PLD_READY, f_valid,
                                            state_q};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            ctrl_q <= `RIF_CTRL_RST;
            dh_q <= `RIF_DEST_RST;
            dl_q <= `RIF_DEST_RST;
            rdata_q <= 32'h0000_0000;
        end else begin
            ctrl_q <= ctrl_d;
            dh_q <= dh_d;
            dl_q <= dl_d;
            rdata_q <= rdata_d;
        end
    end

    // Checker helper: sum of bytes taken from the type byte onward
    logic [4:0] tk_q;
    logic [7:0] chk_q;
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N || (TX_VALID && TX_READY && TX_LAST)) begin
            tk_q <= 5'h00;
            chk_q <= 8'h00;
        end else if (TX_VALID && TX_READY) begin
            tk_q <= (tk_q == 5'h1F) ? tk_q : tk_q + 5'h01;
            chk_q <= (tk_q >= `RIF_IDX_TYPE) ? chk_q + TX_DATA : chk_q;
        end
    end

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    property p_upd_frame;
        upd_take && api_en |=> state_q == RIF_HDR && kind_q == RIF_K_ADDR
            && dh_q == addr_a_q[63:32];
    endproperty
    a_upd_frame: assert property (p_upd_frame) else $error("update frame not started");
    property p_fmt_id;
        fire && kind_q == RIF_K_ADDR && idx_q == `RIF_IDX_FID |=> out_data_q == 8'h00;
    endproperty
    a_fmt_id: assert property (p_fmt_id) else $error("format id not zero");
    property p_old_lsb;
        fire && kind_q == RIF_K_ADDR && idx_q == `RIF_IDX_OLD_LAST
            |=> out_data_q == addr_b_q[7:0];
    endproperty
    a_old_lsb: assert property (p_old_lsb) else $error("old address LSB wrong");
    property p_leg_type;
        fire && kind_q == RIF_K_LEGACY && idx_q == `RIF_IDX_TYPE |=> out_data_q == 8'h80;
    endproperty
    a_leg_type: assert property (p_leg_type) else $error("legacy type wrong");
    property p_src_msb;
        fire && kind_q != RIF_K_ADDR && idx_q == `RIF_IDX_FID
            |=> out_data_q == addr_a_q[63:56];
    endproperty
    a_src_msb: assert property (p_src_msb) else $error("source MSB wrong");
    property p_rssi;
        fire && kind_q == RIF_K_LEGACY && idx_q == `RIF_IDX_RSSI |=> out_data_q == rssi_q;
    endproperty
    a_rssi: assert property (p_rssi) else $error("rssi byte wrong");
    property p_rsv;
        fire && kind_q == RIF_K_STD && idx_q == `RIF_IDX_RSV0
            ##1 fire && idx_q == `RIF_IDX_RSV1 |=> out_data_q == 8'hFE;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bytes wrong");
    property p_std_pld;
        fire && kind_q == RIF_K_STD && idx_q == `RIF_IDX_STD_OPT && rem_q != '0
            |=> state_q == RIF_PLD && out_data_q == opt_q;
    endproperty
    a_std_pld: assert property (p_std_pld) else $error("payload not at 15");
    property p_csum;
        TX_VALID && TX_READY && TX_LAST |-> 8'(chk_q + TX_DATA) == 8'hFF;
    endproperty
    a_csum: assert property (p_csum) else $error("checksum wrong");

    c_addr: cover property (upd_take && api_en ##[1:60] TX_LAST);
    c_leg: cover property (rx_take && fmt_sel == `RIF_FMT_LEGACY ##[1:200] TX_LAST);
    c_std: cover property (rx_take && fmt_sel == `RIF_FMT_STD ##[1:200] TX_LAST);
endmodule : rif_framer

// >>> tb/rif_host_model.sv
// Host-side model: reads the framer's byte stream, splits frames, checks sums.
// Assumes TX_LAST marks the checksum byte and one byte moves per accepted cycle.
`timescale 1ns/1ps
module rif_host_model (
    input wire logic clk,
    input wire logic stall,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [7:0] tx_data,
    input wire logic tx_last
);
    logic [7:0] cur_q[$];
    logic [7:0] last_q[$];
    logic [7:0] opt_q;
    logic [7:0] sum;
    logic [1:0] cnt;
    int frames;
    int csum_bad;
    initial begin
        tx_ready = 1'b0;
        cnt = 2'h0;
        opt_q = 8'h00;
        frames = 0;
        csum_bad = 0;
    end
    // With stall set, the host takes one byte in four, so the framer must hold its byte
    always @(posedge clk) begin
        cnt <= cnt + 2'h1;
        tx_ready <= stall ? (cnt == 2'h0) : 1'b1;
        if (tx_valid && tx_ready) begin
            if ((cur_q.size() == 13 && cur_q[3] == 8'h80) ||
                (cur_q.size() == 14 && cur_q[3] == 8'h90)) begin
                opt_q <= tx_data & 8'hC3;
            end
            cur_q.push_back(tx_data);
            if (tx_last) begin
                sum = 8'h00;
                for (int i = 3; i < cur_q.size(); i++) begin
                    sum = sum + cur_q[i];
                end
                if (sum !== 8'hFF) begin
                    csum_bad++;
                end
                last_q = cur_q;
                cur_q.delete();
                frames++;
            end
        end
    end
endmodule : rif_host_model

// >>> tb/rif_framer_tb_top.sv
// Self-checking bench for the receive-notification framer.
// Assumes the design files are compiled first; the host model drives TX_READY.
`timescale 1ns/1ps
module rif_framer_tb_top;
    typedef logic [7:0] rif_bytes_t[$];
    logic CORE_CLK, RST_N, REG_WR, REG_RD, UPD_VALID, UPD_READY, RX_VALID, RX_READY;
    logic RX_ACKED, RX_BCAST, PLD_VALID, PLD_READY, TX_VALID, TX_READY, TX_LAST, stall;
    logic [7:0] REG_ADDR, RX_RSSI, RX_LEN, PLD_DATA, TX_DATA;
    logic [31:0] REG_WDATA, REG_RDATA;
    logic [63:0] UPD_ADDR, RX_SRC_ADDR, old_a, new_a;
    logic [1:0] RX_METHOD;
    rif_bytes_t body, pl;
    int fails, checks;

    rif_framer #(.LEN_W(8), .FIFO_DEPTH(32)) rif_framer_inst (
        .CORE_CLK(CORE_CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
        .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .UPD_VALID(UPD_VALID),
        .UPD_READY(UPD_READY), .UPD_ADDR(UPD_ADDR), .RX_VALID(RX_VALID), .RX_READY(RX_READY),
        .RX_SRC_ADDR(RX_SRC_ADDR), .RX_RSSI(RX_RSSI), .RX_ACKED(RX_ACKED), .RX_BCAST(RX_BCAST),
        .RX_METHOD(RX_METHOD), .RX_LEN(RX_LEN), .PLD_VALID(PLD_VALID), .PLD_READY(PLD_READY),
        .PLD_DATA(PLD_DATA), .TX_VALID(TX_VALID), .TX_READY(TX_READY), .TX_DATA(TX_DATA),
        .TX_LAST(TX_LAST));
    rif_host_model rif_host_model_inst (.clk(CORE_CLK), .stall(stall), .tx_valid(TX_VALID),
        .tx_ready(TX_READY), .tx_data(TX_DATA), .tx_last(TX_LAST));

    initial begin
        CORE_CLK = 1'b0;
        forever #12.5 CORE_CLK = ~CORE_CLK;
    end

    task automatic stop_test();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test

    task automatic cmp32(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s exp %h got %h", what, exp, got);
        end
    endtask : cmp32

    task automatic cmp_frame(input string what, input rif_bytes_t exp, input rif_bytes_t got);
        checks++;
        if (got.size() != exp.size()) begin
            fails++;
            $display("[FAIL] %s size exp %0d got %0d", what, exp.size(), got.size());
        end else begin
            foreach (exp[i]) begin
                if (got[i] !== exp[i]) begin
                    fails++;
                    $display("[FAIL] %s byte %0d exp %h got %h", what, i, exp[i], got[i]);
                    break;
                end
            end
        end
    endtask : cmp_frame

    // Ready is looked at mid-cycle, away from the edge where the bench drives
    task automatic hs_wait(input int which);
        logic r;
        int n;
        r = 1'b0;
        n = 0;
        while (!r) begin
            @(negedge CORE_CLK);
            r = ((which == 0) ? PLD_READY : (which == 1) ? RX_READY : UPD_READY) === 1'b1;
            @(posedge CORE_CLK);
            n++;
            if (n > 3000) begin
                fails++;
                $display("[FAIL] handshake %0d exp ready got timeout", which);
                stop_test();
            end
        end
    endtask : hs_wait

    task automatic wait_frame(input int n);
        int k;
        k = 0;
        while (rif_host_model_inst.frames != n) begin
            @(negedge CORE_CLK);
            k++;
            if (k > 3000) begin
                fails++;
                $display("[FAIL] frame %0d exp done got timeout", n);
                stop_test();
            end
        end
    endtask : wait_frame

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CORE_CLK);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= d;
        @(posedge CORE_CLK);
        REG_WR <= 1'b0;
    endtask : reg_wr

    task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge CORE_CLK);
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        @(posedge CORE_CLK);
        REG_RD <= 1'b0;
        @(negedge CORE_CLK);
        cmp32(what, exp, REG_RDATA);
    endtask : chk_reg

    task automatic send_upd(input logic [63:0] a);
        @(posedge CORE_CLK);
        UPD_VALID <= 1'b1;
        UPD_ADDR <= a;
        hs_wait(2);
        UPD_VALID <= 1'b0;
    endtask : send_upd

    task automatic send_rx(input logic [63:0] s, input logic [7:0] rssi, input logic ack,
                           input logic bc, input logic [1:0] m, input logic [7:0] len);
        @(posedge CORE_CLK);
        RX_VALID <= 1'b1;
        RX_SRC_ADDR <= s;
        RX_RSSI <= rssi;
        RX_ACKED <= ack;
        RX_BCAST <= bc;
        RX_METHOD <= m;
        RX_LEN <= len;
        hs_wait(1);
        RX_VALID <= 1'b0;
    endtask : send_rx

    task automatic push_all(input rif_bytes_t p);
        foreach (p[i]) begin
            @(posedge CORE_CLK);
            PLD_VALID <= 1'b1;
            PLD_DATA <= p[i];
            hs_wait(0);
            PLD_VALID <= 1'b0;
        end
    endtask : push_all

    function automatic rif_bytes_t be64(input logic [63:0] a);
        rif_bytes_t q;
        for (int i = 7; i >= 0; i--) begin
            q.push_back(a[i*8+:8]);
        end
        return q;
    endfunction : be64

    function automatic rif_bytes_t mk_frame(input logic [7:0] ty, input rif_bytes_t b);
        rif_bytes_t f;
        logic [15:0] n;
        logic [7:0] s;
        n = 16'(b.size() + 1);
        s = ty;
        foreach (b[i]) begin
            s = s + b[i];
        end
        f = {8'h7E, n[15:8], n[7:0], ty};
        f = {f, b, 8'hFF - s};
        return f;
    endfunction : mk_frame

    initial begin
        {RST_N, REG_WR, REG_RD, UPD_VALID, RX_VALID, RX_ACKED, RX_BCAST, PLD_VALID, stall} = '0;
        {REG_ADDR, RX_RSSI, RX_LEN, PLD_DATA, RX_METHOD} = '0;
        {REG_WDATA, UPD_ADDR, RX_SRC_ADDR} = '0;
        fails = 0;
        checks = 0;
        repeat (2) @(posedge CORE_CLK);
        RST_N <= 1'b1;
        chk_reg(8'h00, 32'h0000_0001, "ctrl reset");
        chk_reg(8'h04, 32'h0000_0000, "dest high reset");
        reg_wr(8'h10, 32'hFFFF_FFFF);
        chk_reg(8'h10, 32'h0000_0000, "unmapped read");
        chk_reg(8'h00, 32'h0000_0001, "ctrl kept");
        $display("test registers done");
        old_a = 64'h0013_A200_4052_AAAA;
        new_a = 64'h0013_A200_4052_BBBB;
        reg_wr(8'h04, old_a[63:32]);
        reg_wr(8'h08, old_a[31:0]);
        send_upd(new_a);
        wait_frame(1);
        body = {8'h00, be64(new_a), be64(old_a)};
        cmp_frame("update frame", mk_frame(8'h8E, body), rif_host_model_inst.last_q);
        cmp32("update sum", 32'h0000_0019, 32'(rif_host_model_inst.last_q[21]));
        chk_reg(8'h08, new_a[31:0], "dest low updated");
        $display("test update done");
        pl.delete();
        for (int i = 0; i < 32; i++) begin
            pl.push_back(8'(i * 7 + 3));
        end
        push_all(pl);
        @(negedge CORE_CLK);
        cmp32("fifo full ready", 32'h0, 32'(PLD_READY));
        stall <= 1'b1;
        send_rx(64'h0013_A200_4052_2BAA, 8'h30, 1'b1, 1'b0, 2'b10, 8'd32);
        wait_frame(2);
        stall <= 1'b0;
        body = {be64(64'h0013_A200_4052_2BAA), 8'hFF, 8'hFE, 8'h81, pl};
        cmp_frame("std frame", mk_frame(8'h90, body), rif_host_model_inst.last_q);
        cmp32("std opt", 32'h0000_0081, 32'(rif_host_model_inst.opt_q));
        $display("test standard done");
        reg_wr(8'h00, 32'h0000_0005);
        pl = {8'h52, 8'h78, 8'h44, 8'h61, 8'h74, 8'h61};
        send_rx(64'h0013_A200_4052_C507, 8'd40, 1'b0, 1'b1, 2'b01, 8'd6);
        push_all(pl);
        wait_frame(3);
        body = {be64(64'h0013_A200_4052_C507), 8'h28, 8'h42, pl};
        cmp_frame("legacy frame", mk_frame(8'h80, body), rif_host_model_inst.last_q);
        cmp32("legacy opt", 32'h0000_0042, 32'(rif_host_model_inst.opt_q));
        $display("test legacy done");
        reg_wr(8'h00, 32'h0000_0004);
        send_upd(old_a);
        chk_reg(8'h08, old_a[31:0], "dest low api off");
        send_rx(64'h1, 8'h10, 1'b1, 1'b1, 2'b11, 8'd2);
        push_all(pl[0:1]);
        reg_wr(8'h00, 32'h0000_0007);
        send_rx(64'h2, 8'h10, 1'b1, 1'b1, 2'b11, 8'd1);
        push_all(pl[2:2]);
        reg_wr(8'h00, 32'h0000_0001);
        send_rx(64'h0013_A200_4052_0001, 8'h11, 1'b0, 1'b1, 2'b11, 8'd0);
        wait_frame(4);
        body = {be64(64'h0013_A200_4052_0001), 8'hFF, 8'hFE, 8'hC2};
        cmp_frame("empty std frame", mk_frame(8'h90, body), rif_host_model_inst.last_q);
        cmp32("empty std opt", 32'h0000_00C2, 32'(rif_host_model_inst.opt_q));
        chk_reg(8'h0C, 32'h0004_0021, "status idle");
        cmp32("host sums", 32'h0, 32'(rif_host_model_inst.csum_bad));
        $display("test refusals done");
        stop_test();
    end
endmodule : rif_framer_tb_top
